// File: abs_ctrl.v
// Sleep, busy/interrupt and range control of an eight-channel sampling converter
// Contract
// [R1] Auto-sleep low: conversion starts with no added delay.
// [R2] Auto-sleep high: hold and conversion begin six conversion clocks after start.
// [R3] Host should pick auto-sleep at low data rates to save power.
// [R4] Select bit 0: shared status output is a busy indicator.
// [R5] Busy mode: high on start, low one conversion clock per finished pair.
// [R6] Busy mode: after the last started pair finishes, output stays low.
// [R7] Select bit 1: output is an interrupt, set at completion, held until cleared.
// [R8] Pair A is the master pair, always active, never powered down.
// [R9] Pair A range: range pin in hardware mode, config bit 24 in software mode.
// [R10] Pair B range: range pin in hardware mode, config bit 23 in software mode.
// [R11] Interface select low picks parallel, high picks serial pin roles.
// [R12] Rising edge of a pair start input converts both inputs of that pair.
// [R13] Pair C range: range pin in hardware mode, config bit 21 in software mode.
// [R14] Interrupt clear is an input of selectable polarity plus a software clear.
//
// Our own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`include "abs_regs.vh"
module abs_ctrl
#(
  parameter CLEAR_ACTIVE_HIGH = 1
)
(
  input wire clk,
  input wire rst,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Pins from the host side, asynchronous
  input wire [3:0] pair_conversion_start,
  input wire auto_sleep_enable,
  input wire interface_select,
  input wire hw_mode,
  input wire range_pin,
  input wire irq_clear_in,
  // Converter side
  output wire [3:0] pair_hold,
  output reg range_a,
  output reg range_b,
  output reg range_c,
  output reg parallel_active,
  output reg serial_active,
  output reg busy_irq_out
);
  localparam [31:0] LOW_CLKS_W = `ABS_CCLK_DIV;
  localparam [7:0] LOW_CLKS = LOW_CLKS_W[7:0];
  localparam [31:0] CFG_RESET = `ABS_CFG_RESET;
  localparam [31:0] CFG_MASK = `ABS_CFG_MASK;

  // Byte-lane merge of a write into a register
  function [31:0] abs_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] be;
    integer i;
    begin
      abs_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          abs_merge[i*8 +: 8] = data[i*8 +: 8];
    end
  endfunction

  // Word select of the slave bus; the low two address bits are byte lanes
  function abs_sel;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      abs_sel = (addr[3:2] == ofs[3:2]);
    end
  endfunction

  // Range source: pin in hardware mode, configuration bit in software mode
  function abs_range;
    input hw;
    input pin;
    input cfg;
    begin
      abs_range = hw ? pin : cfg;
    end
  endfunction

  // Number of pairs finishing in one clock, widened to the counter
  function [15:0] abs_count;
    input [3:0] d;
    integer i;
    begin
      abs_count = 16'h0000;
      for (i = 0; i < 4; i = i + 1)
        abs_count = abs_count + {15'h0000, d[i]};
    end
  endfunction

  // Synchronisers: first stage feeds only the second
  reg [3:0] start_meta;
  reg [3:0] start_sync;
  reg [3:0] start_prev;
  reg [4:0] lvl_meta;
  reg [4:0] lvl_sync;

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_meta <= 4'h0;
      start_sync <= 4'h0;
      start_prev <= 4'h0;
      lvl_meta <= 5'h00;
      lvl_sync <= 5'h00;
    end
    else
    begin
      start_meta <= pair_conversion_start;
      start_sync <= start_meta;
      start_prev <= start_sync;
      lvl_meta <= {irq_clear_in, range_pin, hw_mode, interface_select, auto_sleep_enable};
      lvl_sync <= lvl_meta;
    end
  end

  // Synchronised pin levels, the clear taken in its active sense
  wire sleep_s = lvl_sync[0];
  wire ser_s = lvl_sync[1];
  wire hw_s = lvl_sync[2];
  wire range_s = lvl_sync[3];
  wire clr_s = (CLEAR_ACTIVE_HIGH != 0) ? lvl_sync[4] : ~lvl_sync[4];
  // Rising edge of each pair start input
  wire [3:0] start_rise = start_sync & ~start_prev; // [R12]

  // Registers
  reg [31:0] config_reg;
  reg irq_flag;
  reg [15:0] done_count;
  reg ack;

  wire busy_irq_select_bit = config_reg[`ABS_CFG_BUSY_IRQ_SEL];
  // Pair A never powers down; only D has a power-down bit here
  wire [3:0] pair_enable = {~config_reg[`ABS_CFG_PD_D], 3'b111}; // [R8]

  // Per-pair state from the sequencers
  wire [3:0] pair_active;
  wire [3:0] pair_done;

  // One sequencer per pair; both inputs of a pair share it
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_pair
      abs_pair_seq u_seq
      (
        .clk(clk),
        .rst(rst),
        .start(start_rise[g]), // [R12]
        .auto_sleep(sleep_s),
        .enable(pair_enable[g]),
        .active(pair_active[g]),
        .hold(pair_hold[g]),
        .done(pair_done[g])
      );
    end
  endgenerate

  // Summary of the four sequencers
  wire any_done = |pair_done;
  wire any_active = |pair_active;
  // Completion of the last running pair: all sequencers idle at the done
  wire last_done = any_done && !any_active;
  // Starts a sequencer accepts; an ignored start must not raise busy
  wire [3:0] start_taken = start_rise & pair_enable & ~pair_active;
  wire any_taken = |start_taken;

  // Low window after each finished pair, one conversion clock long
  reg [7:0] low_cnt;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      low_cnt <= 8'h00;
    end
    else if (any_done)
    begin
      low_cnt <= LOW_CLKS - 8'h01; // [R5]
    end
    else if (low_cnt != 8'h00)
    begin
      low_cnt <= low_cnt - 8'h01;
    end
  end

  // Bus handshake: one wait cycle, then the request is taken
  wire req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;
  wire take = req && ack;
  wire wr_take = take && avs_write;
  wire sw_clear = wr_take && abs_sel(avs_address, `ABS_OFS_CONTROL)
    && avs_byteenable[0] && avs_writedata[`ABS_CTL_IRQ_CLEAR]; // [R14]

  // Interrupt flag: a completion in the clear cycle wins over the clear
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_flag <= 1'b0;
    end
    else if (last_done)
    begin
      irq_flag <= 1'b1; // [R7]
    end
    else if (clr_s || sw_clear)
    begin
      irq_flag <= 1'b0; // [R14]
    end
  end

  // Shared status output, registered
  reg next_out;
  always @*
  begin
    if (busy_irq_select_bit)
    begin
      next_out = irq_flag; // [R7]
    end
    else
    begin
      // Busy mode: high while any pair runs, except in low windows;
      // after the last pair ends nothing is active so it stays low
      next_out = (any_active || any_taken) && !any_done
        && (low_cnt == 8'h00 || any_taken); // [R4] [R5] [R6]
    end
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy_irq_out <= 1'b0;
    end
    else
    begin
      busy_irq_out <= next_out;
    end
  end

  // Range and interface role outputs
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      range_a <= 1'b0;
      range_b <= 1'b0;
      range_c <= 1'b0;
      parallel_active <= 1'b1;
      serial_active <= 1'b0;
    end
    else
    begin
      range_a <= abs_range(hw_s, range_s, config_reg[`ABS_CFG_RANGE_A]); // [R9]
      range_b <= abs_range(hw_s, range_s, config_reg[`ABS_CFG_RANGE_B]); // [R10]
      range_c <= abs_range(hw_s, range_s, config_reg[`ABS_CFG_RANGE_C]); // [R13]
      parallel_active <= !ser_s; // [R11]
      serial_active <= ser_s; // [R11]
    end
  end

  // Completed pair conversions, wraps at 16 bits
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      done_count <= 16'h0000;
    end
    else if (wr_take && abs_sel(avs_address, `ABS_OFS_COUNT))
    begin
      done_count <= 16'h0000;
    end
    else if (any_done)
    begin
      done_count <= done_count + abs_count(pair_done);
    end
  end

  // Register map, one word per offset:
  // configuration is read-write through the writable-bit mask,
  // status is read-only live state, control is write-one-to-clear,
  // count is read-only and cleared by any write.
  // Control reads return zero; writes to status are ignored.
  // Status word assembled from live state
  wire [31:0] status_word = {23'h00_0000, hw_s, pair_active, ser_s, sleep_s,
    irq_flag, busy_irq_out};

  // Acknowledge one clock after the request rises, then drop for a clock;
  // costs a cycle per access but keeps read data registered,
  // and back-to-back requests each see one wait state
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
    end
    else
    begin
      ack <= avs_waitrequest;
    end
  end

  // Read data latched in the wait cycle, so it stands at the taking edge
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if (avs_read && !ack)
    begin
      case (avs_address[3:2])
        2'b00: avs_readdata <= config_reg;
        2'b01: avs_readdata <= status_word;
        2'b11: avs_readdata <= {16'h0000, done_count};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration word; bits outside the mask always read as zero
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_reg <= CFG_RESET;
    end
    else if (wr_take && abs_sel(avs_address, `ABS_OFS_CONFIG))
    begin
      config_reg <= abs_merge(config_reg, avs_writedata, avs_byteenable) & CFG_MASK;
    end
  end
endmodule // abs_ctrl

// File: abs_regs.vh
// Register map, field positions, reset values and timing counts of the sleep/busy control
`ifndef ABS_REGS_VH
`define ABS_REGS_VH

// Byte offsets on the register bus
`define ABS_OFS_CONFIG 4'h0
`define ABS_OFS_STATUS 4'h4
`define ABS_OFS_CONTROL 4'h8
`define ABS_OFS_COUNT 4'hC

// Configuration word fields
`define ABS_CFG_BUSY_IRQ_SEL 27
`define ABS_CFG_RANGE_A 24
`define ABS_CFG_RANGE_B 23
`define ABS_CFG_RANGE_C 21
`define ABS_CFG_PD_D 18
`define ABS_CFG_RESET 32'h0000_0000
// Writable bits of the configuration word
`define ABS_CFG_MASK 32'h09A4_0000

// Status word fields
`define ABS_ST_OUT 0
`define ABS_ST_IRQ 1
`define ABS_ST_SLEEP 2
`define ABS_ST_SERIAL 3
`define ABS_ST_PAIR_LO 4
`define ABS_ST_HW_MODE 8

// Control word fields (write one)
`define ABS_CTL_IRQ_CLEAR 0

// Timing: conversion clock period in ns, system clock period in ns
`define ABS_CCLK_PERIOD_NS 40
`define ABS_CLK_PERIOD_NS 8
// System clocks per conversion clock
`define ABS_CCLK_DIV (`ABS_CCLK_PERIOD_NS / `ABS_CLK_PERIOD_NS)
// Conversion clocks of auto-sleep delay before hold
`define ABS_SLEEP_CCLK 6
// Conversion clocks that one pair conversion takes
`define ABS_CONV_CCLK 19
`define ABS_SLEEP_CLKS (`ABS_SLEEP_CCLK * `ABS_CCLK_DIV)
`define ABS_CONV_CLKS (`ABS_CONV_CCLK * `ABS_CCLK_DIV)

`endif

// File: abs_pair_seq.v
// Per-pair sequencer: optional auto-sleep wait, then hold and conversion
`timescale 1ns/100ps
`include "abs_regs.vh"
module abs_pair_seq
(
  input wire clk,
  input wire rst,
  input wire start,
  input wire auto_sleep,
  input wire enable,
  output reg active,
  output reg hold,
  output reg done
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_SLEEP = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;
  localparam [31:0] SLEEP_CLKS_W = `ABS_SLEEP_CLKS;
  localparam [31:0] CONV_CLKS_W = `ABS_CONV_CLKS;
  localparam [7:0] SLEEP_LAST = SLEEP_CLKS_W[7:0] - 8'h01;
  localparam [7:0] CONV_LAST = CONV_CLKS_W[7:0] - 8'h01;

  reg [1:0] state;
  reg [7:0] cnt;

  // Starts during a running conversion are ignored; the pair finishes first
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      cnt <= 8'h00;
      active <= 1'b0;
      hold <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          cnt <= 8'h00;
          if (start && enable)
          begin
            active <= 1'b1;
            if (auto_sleep)
            begin
              state <= ST_SLEEP; // [R2]
            end
            else
            begin
              state <= ST_CONV; // [R1]
              hold <= 1'b1;
            end
          end
        end
        ST_SLEEP:
        begin
          if (cnt == SLEEP_LAST)
          begin
            cnt <= 8'h00;
            state <= ST_CONV; // [R2]
            hold <= 1'b1;
          end
          else
          begin
            cnt <= cnt + 8'h01;
          end
        end
        ST_CONV:
        begin
          if (cnt == CONV_LAST)
          begin
            cnt <= 8'h00;
            state <= ST_IDLE;
            active <= 1'b0;
            hold <= 1'b0;
            done <= 1'b1;
          end
          else
          begin
            cnt <= cnt + 8'h01;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          active <= 1'b0;
          hold <= 1'b0;
        end
      endcase
    end
  end
endmodule // abs_pair_seq

// File: abs_ctrl_chk.sv
// Checker for start timing, busy shape and interrupt hold at the control ports
`timescale 1ns/100ps
module abs_ctrl_chk
(
  input wire clk,
  input wire rst,
  input wire [3:0] avs_address,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire avs_waitrequest,
  input wire [3:0] pair_conversion_start,
  input wire auto_sleep_enable,
  input wire irq_clear_in,
  input wire [3:0] pair_hold,
  input wire busy_irq_out
);
  reg irq_mode; // Select bit as software last wrote it
  reg [3:0] clr; // Clear requests of the last four clocks
  wire take = avs_write && !avs_waitrequest;
  wire [3:0] st = pair_conversion_start;
  wire q = auto_sleep_enable;
  wire b = busy_irq_out;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Mirror of the mode bit and clear history, since the registers are hidden
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      irq_mode <= 1'b0;
      clr <= 4'h0;
    end
    else
    begin
      clr <= {clr[2:0], irq_clear_in | (take && avs_address[3:2] == 2'h2)};
      if (take && avs_address[3:2] == 2'h0 && avs_byteenable[3])
        irq_mode <= avs_writedata[27];
    end
  property p_norm;
    $rose(st[0]) && !q && !pair_hold[0] |-> ##[1:8] $rose(pair_hold[0]);
  endproperty
  a_norm: assert property (p_norm) else $error("hold late");
  property p_pair_b;
    $rose(st[1]) && !q && !pair_hold[1] |-> ##[1:8] $rose(pair_hold[1]);
  endproperty
  a_pair_b: assert property (p_pair_b) else $error("pair b hold late");
  property p_sleep;
    $rose(st[0]) && q && !pair_hold[0] |-> ##[28:40] $rose(pair_hold[0]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep delay wrong");
  property p_busy_on;
    $rose(|pair_hold) && !irq_mode |-> b;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy low");
  property p_busy_gap;
    $fell(b) && !irq_mode |-> !b [*5];
  endproperty
  a_busy_gap: assert property (p_busy_gap) else $error("busy gap short");
  property p_busy_last;
    $fell(b) && !irq_mode ##5 pair_hold == 4'h0 |-> !b [*3];
  endproperty
  a_busy_last: assert property (p_busy_last) else $error("busy back high");
  property p_irq_set;
    $fell(|pair_hold) && irq_mode |-> ##[0:3] b;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not set");
  property p_irq_keep;
    $fell(b) && irq_mode |-> |clr;
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
endmodule // abs_ctrl_chk

bind abs_ctrl abs_ctrl_chk chk (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .pair_conversion_start(pair_conversion_start),
  .auto_sleep_enable(auto_sleep_enable), .irq_clear_in(irq_clear_in),
  .pair_hold(pair_hold), .busy_irq_out(busy_irq_out));

// File: abs_host_model.sv
// Host model: drives conversion starts and the auto-sleep choice
`timescale 1ns/100ps
module abs_host_model
(
  input wire clk,
  input wire [3:0] fire,
  input wire slow,
  output reg [3:0] pair_conversion_start = 4'h0,
  output reg auto_sleep_enable = 1'b0
);
  // Registered pin drive; only the rising start edge matters to the device
  always @(posedge clk)
  begin
    pair_conversion_start <= fire;
    auto_sleep_enable <= slow; // Sleep pays off at low rates
  end
endmodule // abs_host_model

// File: abs_ctrl_tb.sv
// Self-checking bench for the sleep, busy/interrupt and range control
`timescale 1ns/100ps
module abs_ctrl_tb;
  reg clk, avs_read = 1'b0, avs_write = 1'b0, slow = 1'b0, rst = 1'b1;
  reg hw_mode = 1'b0, range_pin = 1'b0, irq_clear_in = 1'b0, interface_select = 1'b0;
  reg [3:0] avs_address = 4'h0, avs_byteenable = 4'hF, fire = 4'h0;
  reg [31:0] avs_writedata = 32'h0000_0000, rd;
  wire [31:0] avs_readdata;
  wire [3:0] pair_conversion_start, pair_hold;
  wire avs_waitrequest, auto_sleep_enable, range_a, range_b, range_c;
  wire parallel_active, serial_active, busy_irq_out;
  integer err_count = 0, tests_run = 0, cyc = 0, n;
  abs_ctrl uut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pair_conversion_start(pair_conversion_start), .auto_sleep_enable(auto_sleep_enable),
    .interface_select(interface_select), .hw_mode(hw_mode), .range_pin(range_pin),
    .irq_clear_in(irq_clear_in), .pair_hold(pair_hold), .range_a(range_a),
    .range_b(range_b), .range_c(range_c), .parallel_active(parallel_active),
    .serial_active(serial_active), .busy_irq_out(busy_irq_out));
  abs_host_model host (.clk(clk), .fire(fire), .slow(slow),
    .pair_conversion_start(pair_conversion_start), .auto_sleep_enable(auto_sleep_enable));
  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // A hang counts as a mismatch
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      err_count = err_count + 1;
      final_report;
    end
  end
  task final_report;
  begin
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task wait_cyc(input integer k);
    repeat (k) @(posedge clk);
  endtask
  // Request stands until waitrequest is sampled low; edge values are pre-update
  task bus(input wr, input [3:0] a, input [31:0] d, input [3:0] be);
  begin
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  end
  endtask
  task pulse(input [3:0] m);
  begin
    fire <= m;
    wait_cyc(3);
    fire <= 4'h0;
  end
  endtask
  // Counts clocks while the status output holds level v
  task count_while(input v);
  begin
    n = 0;
    while (busy_irq_out === v && n < 300)
    begin
      n = n + 1;
      @(posedge clk);
    end
  end
  endtask
  task t_start(input s);
  begin
    slow <= s;
    wait_cyc(8);
    pulse(4'h1);
    n = 0;
    while (pair_hold[0] !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n = n + 1;
    end
    wait_cyc(110);
  end
  endtask
  task t_regs;
  begin
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
    check(rd, 32'h09A4_0000);
    bus(1'b0, 4'h8, 32'h0000_0000, 4'hF);
    check(rd, 32'h0000_0000);
    check({range_a, range_b, range_c}, 3'h7);
    bus(1'b1, 4'h0, 32'h0000_0000, 4'h4);
    wait_cyc(2);
    check({range_a, range_b, range_c}, 3'h4);
    bus(1'b1, 4'h0, 32'h0020_0000, 4'hF);
    wait_cyc(2);
    check({range_a, range_b, range_c}, 3'h1);
    hw_mode <= 1'b1;
    range_pin <= 1'b1;
    wait_cyc(6);
    check({range_a, range_b, range_c}, 3'h7);
    range_pin <= 1'b0;
    interface_select <= 1'b1;
    wait_cyc(6);
    check({range_a, range_b, range_c}, 3'h0);
    check({serial_active, parallel_active}, 2'h2);
    hw_mode <= 1'b0;
    interface_select <= 1'b0;
    wait_cyc(6);
    check({serial_active, parallel_active}, 2'h1);
    bus(1'b1, 4'h0, 32'h0000_0000, 4'hF);
  end
  endtask
  task t_timing;
  begin
    t_start(1'b0);
    check(n >= 1 && n <= 8, 1'b1);
    t_start(1'b1);
    check(n >= 28 && n <= 40, 1'b1);
    slow <= 1'b0;
    wait_cyc(8);
  end
  endtask
  // Two staggered pairs: one gap, then low after the last
  task t_busy;
  begin
    bus(1'b1, 4'hC, 32'h0000_0000, 4'hF);
    pulse(4'h1);
    wait_cyc(17);
    check(busy_irq_out, 1'b1);
    pulse(4'h2);
    count_while(1'b1);
    count_while(1'b0);
    check(n, 32'h0000_0005);
    wait_cyc(110);
    check(busy_irq_out, 1'b0);
    bus(1'b0, 4'hC, 32'h0000_0000, 4'hF);
    check(rd[15:0], 16'h0002);
  end
  endtask
  task t_pdd;
  begin
    bus(1'b1, 4'h0, 32'h0004_0000, 4'h4);
    pulse(4'h9);
    wait_cyc(8);
    check(pair_hold, 4'h1);
    wait_cyc(110);
    bus(1'b1, 4'h0, 32'h0000_0000, 4'hF);
  end
  endtask
  task t_irq;
  begin
    bus(1'b1, 4'h0, 32'h0800_0000, 4'h8);
    bus(1'b1, 4'h8, 32'h0000_0001, 4'h1);
    wait_cyc(2);
    check(busy_irq_out, 1'b0);
    pulse(4'h1);
    wait_cyc(130);
    check(busy_irq_out, 1'b1);
    irq_clear_in <= 1'b1;
    wait_cyc(4);
    irq_clear_in <= 1'b0;
    wait_cyc(4);
    check(busy_irq_out, 1'b0);
    pulse(4'h1);
    wait_cyc(130);
    check(busy_irq_out, 1'b1);
    bus(1'b1, 4'h8, 32'h0000_0001, 4'h1);
    wait_cyc(2);
    check(busy_irq_out, 1'b0);
    bus(1'b1, 4'h0, 32'h0000_0000, 4'hF);
  end
  endtask
  // Reset for five clocks, then the scenarios in turn
  initial
  begin
    wait_cyc(5);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_timing;
    t_busy;
    t_pdd;
    t_irq;
    final_report;
  end
endmodule // abs_ctrl_tb
